/* shared/rtcp_regs.vh */
// register offsets, field positions, reset values and timing counts of the prescaler/timer block
`ifndef RTCP_REGS_VH
`define RTCP_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTCP_ADDR_CLK_OUT_CTRL   8'h0D
`define RTCP_ADDR_COUNTDOWN_CTRL 8'h0E
`define RTCP_ADDR_COUNTDOWN_VAL  8'h0F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCP_ENABLE_BIT          7
`define RTCP_SEL_MSB             1
`define RTCP_SEL_LSB             0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTCP_RST_CLK_OUT_ENABLE  1'b1
`define RTCP_RST_CLK_OUT_SEL     2'b00
`define RTCP_RST_CD_ENABLE       1'b0
`define RTCP_RST_CD_SEL          2'b11
`define RTCP_RST_CD_VALUE        8'h00

// ----------------------------------------------------------------
// selector encodings
// ----------------------------------------------------------------
`define RTCP_CLK_SEL_32K         2'b00
`define RTCP_CLK_SEL_1K          2'b01
`define RTCP_CLK_SEL_32HZ        2'b10
`define RTCP_CLK_SEL_1HZ         2'b11
`define RTCP_CD_SEL_4K           2'b00
`define RTCP_CD_SEL_64HZ         2'b01
`define RTCP_CD_SEL_1HZ          2'b10
`define RTCP_CD_SEL_MIN          2'b11

// ----------------------------------------------------------------
// prescaler taps and counts (prescaler bit k runs at 16384 / 2^k Hz)
// ----------------------------------------------------------------
`define RTCP_TAP_4K              2
`define RTCP_TAP_1K              4
`define RTCP_TAP_64HZ            8
`define RTCP_TAP_32HZ            9
`define RTCP_TAP_1HZ             14
`define RTCP_HALT_LOW_BITS       2
`define RTCP_MIN_DIV             6'h3B
`define RTCP_TEST_SEC_BIT        5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCP_CLK_PERIOD_NS       20
`define RTCP_IRQ_PULSE_NS        15625

`endif

/* verilog/rtcp_sync.v */
// two flip-flop synchroniser for pin-level inputs
module rtcp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             reset_n,
  // asynchronous in, synchronous out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // rtcp_sync

/* verilog/rtcp_timer.v */
// prescaler, clock output and countdown timer of the real-time clock
`include "rtcp_regs.vh"

// What this block does
// - clock output select: 32k, 1k, 32Hz, 1Hz
// - enable bit low floats clock output pin
// - defaults: output enabled, 32k selected
// - 8-bit down-counter, loaded by software
// - source select: 4096, 64, 1, 1/60 Hz
// - counts only when enable set, default off
// - countdown end sets flag
// - flag cleared only by host
// - irq pulses or follows flag per mode
// - read returns live countdown value
// - period is n over source frequency
// - test mode: pin becomes 64Hz input
// - test mode: 64 edges per second
// - halt in test zeroes prescaler, holds
// - after test halt: 32, then 64 edges
// - halt holds upper stages, no seconds
// - halt keeps 32k output, stops others
// - lowest two stages ignore halt
// - first second about half second after release
module rtcp_timer #(
  parameter IRQ_PULSE_CYC = (`RTCP_IRQ_PULSE_NS + `RTCP_CLK_PERIOD_NS - 1) / `RTCP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // register port from the serial engine
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_we,
  input  wire       reg_re,
  output reg  [7:0] reg_rdata,
  // control bits held elsewhere
  input  wire       time_halt,
  input  wire       ext_clock_test_enable,
  input  wire       countdown_irq_pulse_mode,
  input  wire       countdown_flag_clear,
  // oscillator and clock output pin
  input  wire       osc_32k,
  input  wire       clock_output_pin_in,
  output reg        clock_output_pin_out,
  output reg        clock_output_pin_oe,
  // status and interrupt
  output reg        countdown_flag,
  output reg        sec_tick,
  output reg        irq_n_out,
  output reg        irq_n_oe
);

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  wire [1:0] pins_sync;
  reg        osc_d_r;
  reg        ext_d_r;
  wire       osc_rise;
  wire       ext_rise;

  rtcp_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({clock_output_pin_in, osc_32k}),
    .sync_out (pins_sync)
  );

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      osc_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end
    else
    begin
      osc_d_r <= pins_sync[0];
      ext_d_r <= pins_sync[1];
    end
  end

  assign osc_rise = pins_sync[0] & ~osc_d_r;
  assign ext_rise = pins_sync[1] & ~ext_d_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg        clk_out_enable_r;
  reg  [1:0] clk_out_freq_sel_r;
  reg        countdown_enable_r;
  reg  [1:0] countdown_src_sel_r;
  reg  [7:0] reload_r;
  reg  [7:0] count_r;
  reg  [7:0] count_nxt;
  reg        load_pend_r;
  wire       wr_clk   = reg_we & (reg_addr == `RTCP_ADDR_CLK_OUT_CTRL);
  wire       wr_cd    = reg_we & (reg_addr == `RTCP_ADDR_COUNTDOWN_CTRL);
  wire       wr_value = reg_we & (reg_addr == `RTCP_ADDR_COUNTDOWN_VAL);

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      clk_out_enable_r    <= `RTCP_RST_CLK_OUT_ENABLE;
      clk_out_freq_sel_r  <= `RTCP_RST_CLK_OUT_SEL;
      countdown_enable_r  <= `RTCP_RST_CD_ENABLE;
      countdown_src_sel_r <= `RTCP_RST_CD_SEL;
    end
    else
    begin
      if (wr_clk)
      begin
        clk_out_enable_r   <= reg_wdata[`RTCP_ENABLE_BIT];
        clk_out_freq_sel_r <= reg_wdata[`RTCP_SEL_MSB:`RTCP_SEL_LSB];
      end
      if (wr_cd)
      begin
        countdown_enable_r  <= reg_wdata[`RTCP_ENABLE_BIT];
        countdown_src_sel_r <= reg_wdata[`RTCP_SEL_MSB:`RTCP_SEL_LSB];
      end
    end
  end

  // read data: live counter, no snapshot, so host double-reads
  always @(posedge mclk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_re)
    begin
      case (reg_addr)
        `RTCP_ADDR_CLK_OUT_CTRL:
          reg_rdata <= {clk_out_enable_r, 5'b0_0000, clk_out_freq_sel_r};
        `RTCP_ADDR_COUNTDOWN_CTRL:
          reg_rdata <= {countdown_enable_r, 5'b0_0000, countdown_src_sel_r};
        `RTCP_ADDR_COUNTDOWN_VAL:
          reg_rdata <= count_r;
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  reg  [14:0] pre_r;
  reg  [14:0] pre_nxt;
  reg  [5:0]  test_pre_r;
  reg  [5:0]  min_div_r;
  reg         sec_src_d_r;
  wire        sec_src;
  wire        sec_rise;

  always @*
  begin
    pre_nxt = pre_r;
    if (osc_rise)
      pre_nxt = pre_r + 15'h0001;
    // upper stages held at zero, low two keep running
    if (time_halt)
      pre_nxt[14:`RTCP_HALT_LOW_BITS] = 13'h0000;
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
      pre_r <= 15'h0000;
    else
      pre_r <= pre_nxt;
  end

  // test divider: 64 pin edges per second, zeroed by halt
  always @(posedge mclk)
  begin
    if (!reset_n)
      test_pre_r <= 6'h00;
    else if (time_halt)
      test_pre_r <= 6'h00;
    else if (ext_clock_test_enable && ext_rise)
      test_pre_r <= test_pre_r + 6'h01;
  end

  // bit 5 rises after 32 edges from zero, then every 64
  assign sec_src = ext_clock_test_enable ? test_pre_r[`RTCP_TEST_SEC_BIT]
                                         : pre_r[`RTCP_TAP_1HZ];

  always @(posedge mclk)
  begin
    if (!reset_n)
      sec_src_d_r <= 1'b0;
    else
      sec_src_d_r <= sec_src;
  end

  assign sec_rise = sec_src & ~sec_src_d_r & ~time_halt;

  always @(posedge mclk)
  begin
    if (!reset_n)
      sec_tick <= 1'b0;
    else
      sec_tick <= sec_rise;
  end

  // ----------------------------------------------------------------
  // countdown source ticks
  // ----------------------------------------------------------------
  reg  [7:0] tap_d_r;
  wire [7:0] taps;
  wire [7:0] tap_rise;
  reg        min_tick;
  reg        cd_tick;

  // test mode bypasses the 64 Hz tap: each pin rising edge outside halt is a countdown tick (see cd_tick)
  assign taps = {6'h00, pre_r[`RTCP_TAP_64HZ], pre_r[`RTCP_TAP_4K]};
  assign tap_rise = taps & ~tap_d_r;

  always @(posedge mclk)
  begin
    if (!reset_n)
      tap_d_r <= 8'h00;
    else
      tap_d_r <= taps;
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      min_div_r <= 6'h00;
      min_tick  <= 1'b0;
    end
    else
    begin
      min_tick <= 1'b0;
      if (sec_rise)
      begin
        if (min_div_r == `RTCP_MIN_DIV)
        begin
          min_div_r <= 6'h00;
          min_tick  <= 1'b1;
        end
        else
          min_div_r <= min_div_r + 6'h01;
      end
    end
  end

  always @*
  begin
    case (countdown_src_sel_r)
      `RTCP_CD_SEL_4K:   cd_tick = tap_rise[0];
      `RTCP_CD_SEL_64HZ: cd_tick = ext_clock_test_enable ? (ext_rise & ~time_halt) : tap_rise[1];
      `RTCP_CD_SEL_1HZ:  cd_tick = sec_rise;
      `RTCP_CD_SEL_MIN:  cd_tick = min_tick;
      default:           cd_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // countdown counter
  // ----------------------------------------------------------------
  wire cd_done = countdown_enable_r & cd_tick & (reload_r != 8'h00) & (count_r == 8'h01);

  always @*
  begin
    count_nxt = count_r;
    if (wr_value)
      count_nxt = reg_wdata;
    else if (countdown_enable_r && cd_tick)
    begin
      if (cd_done)
        count_nxt = reload_r;
      else if (count_r != 8'h00)
        count_nxt = count_r - 8'h01;
      else if (load_pend_r)
        count_nxt = reload_r;
    end
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reload_r    <= `RTCP_RST_CD_VALUE;
      count_r     <= `RTCP_RST_CD_VALUE;
      load_pend_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      if (wr_value)
      begin
        reload_r    <= reg_wdata;
        load_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // flag and interrupt
  // ----------------------------------------------------------------
  reg [15:0] pulse_cnt_r;
  wire       irq_act;

  // a completion in the clearing cycle still sets the flag
  always @(posedge mclk)
  begin
    if (!reset_n)
      countdown_flag <= 1'b0;
    else if (cd_done)
      countdown_flag <= 1'b1;
    else if (countdown_flag_clear)
      countdown_flag <= 1'b0;
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
      pulse_cnt_r <= 16'h0000;
    else if (cd_done)
      pulse_cnt_r <= IRQ_PULSE_CYC[15:0];
    else if (pulse_cnt_r != 16'h0000)
      pulse_cnt_r <= pulse_cnt_r - 16'h0001;
  end

  assign irq_act = countdown_irq_pulse_mode ? (pulse_cnt_r != 16'h0000) : countdown_flag;

  // open drain: only ever pulls low
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= 1'b0;
    end
    else
    begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= irq_act;
    end
  end

  // ----------------------------------------------------------------
  // clock output pin
  // ----------------------------------------------------------------
  reg clk_sel;

  always @*
  begin
    case (clk_out_freq_sel_r)
      `RTCP_CLK_SEL_32K:  clk_sel = pins_sync[0];
      `RTCP_CLK_SEL_1K:   clk_sel = pre_r[`RTCP_TAP_1K] & ~time_halt;
      `RTCP_CLK_SEL_32HZ: clk_sel = pre_r[`RTCP_TAP_32HZ] & ~time_halt;
      `RTCP_CLK_SEL_1HZ:  clk_sel = pre_r[`RTCP_TAP_1HZ] & ~time_halt;
      default:            clk_sel = 1'b0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      clock_output_pin_out <= 1'b0;
      clock_output_pin_oe  <= 1'b0;
    end
    else
    begin
      clock_output_pin_out <= clk_sel;
      // test mode turns the pin round to an input
      clock_output_pin_oe  <= clk_out_enable_r & ~ext_clock_test_enable;
    end
  end

endmodule // rtcp_timer

/* testbench/rtcp_timer_monitor.sv */
// assertion checker on the ports of the prescaler/timer block
module rtcp_timer_monitor #(
  parameter IRQ_PULSE_CYC = 782
) (
  // clock and reset
  input wire       mclk,
  input wire       reset_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_we,
  input wire       reg_re,
  input wire [7:0] reg_rdata,
  // control levels
  input wire       time_halt,
  input wire       ext_clock_test_enable,
  input wire       countdown_irq_pulse_mode,
  input wire       countdown_flag_clear,
  // pins
  input wire       osc_32k,
  input wire       clock_output_pin_in,
  input wire       clock_output_pin_out,
  input wire       clock_output_pin_oe,
  // status
  input wire       countdown_flag,
  input wire       sec_tick,
  input wire       irq_n_out,
  input wire       irq_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // helper: length of the current interrupt assertion
  // ----------------------------------------------------------------
  reg [15:0] hi_cnt_r;
  always @(posedge mclk)
    if (!reset_n)
      hi_cnt_r <= 16'h0000;
    else
      hi_cnt_r <= irq_n_oe ? hi_cnt_r + 16'h0001 : 16'h0000;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  oe_test_a: assert property (ext_clock_test_enable[*4] |-> !clock_output_pin_oe)
    else $error("clock pin driven in test mode");
  halt_tick_a: assert property (time_halt[*4] |-> !sec_tick)
    else $error("second tick while halted");
  tick_gap_a: assert property (sec_tick |=> !sec_tick[*8])
    else $error("second ticks too close");
  flag_hold_a: assert property (countdown_flag && !countdown_flag_clear |=> countdown_flag)
    else $error("flag dropped without clear");
  irq_level_a: assert property (!countdown_irq_pulse_mode && $rose(countdown_flag) |=> irq_n_oe)
    else $error("level interrupt missing");
  irq_drop_a: assert property ((!countdown_irq_pulse_mode && !countdown_flag)[*2] |=> !irq_n_oe)
    else $error("level interrupt without flag");
  pulse_len_a: assert property (countdown_irq_pulse_mode && $fell(irq_n_oe)
    |-> hi_cnt_r == IRQ_PULSE_CYC)
    else $error("interrupt pulse length wrong");
  irq_drive_a: assert property (!irq_n_out)
    else $error("interrupt drive level high");
  rdata_hold_a: assert property (!reg_re |=> $stable(reg_rdata))
    else $error("read data moved without read");

  cover property (sec_tick);
  cover property (countdown_irq_pulse_mode && $rose(irq_n_oe));
  cover property ($rose(countdown_flag));
endmodule // rtcp_timer_monitor

/* testbench/rtcp_host_model.sv */
// host model: single-byte strobed writes and reads
module rtcp_host_model (
  // clock
  input  wire        mclk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_we,
  output logic       reg_re,
  input  wire  [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 8'hFF;
    reg_wdata = 8'hA5;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end
  // released lines flip so a stale value never passes for a fresh one
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_we} = {a, d, 1'b1};
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_we} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 {reg_addr, reg_re} = {a, 1'b1};
    @(posedge mclk);
    #1 {reg_addr, reg_re} = {~a, 1'b0};
    d = reg_rdata;
  endtask
  // counter runs on during a read, so read until two reads agree, at most five reads, then keep the last
  task automatic rd_twice(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] d2;
    rd(a, d2);
    repeat (4)
    begin
      rd(a, d);
      if (d === d2)
        break;
      d2 = d;
    end
  endtask
endmodule // rtcp_host_model

/* testbench/rtcp_timer_test.sv */
// self-checking bench for the prescaler/timer block
module rtcp_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IRQ_PULSE_CYC = 4;
  logic mclk = 0, reset_n = 0, time_halt = 0, ext_clock_test_enable = 0, ext_drv = 0;
  logic countdown_irq_pulse_mode = 0, countdown_flag_clear = 0, osc_32k = 0, irq_q = 0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_we, reg_re, pin_out, pin_oe, countdown_flag, sec_tick, irq_n_out, irq_n_oe;
  wire pin = pin_oe ? pin_out : ext_drv;
  int failures = 0, checks_done = 0, cyc = 0, ticks = 0, irqs = 0;
  logic [7:0] d;

  // ----------------------------------------------------------------
  // clocks, watchdog, event counters
  // ----------------------------------------------------------------
  // oscillator sped up to 8 mclk periods so dividers show quickly
  always #10 mclk = ~mclk;
  always #80 osc_32k = ~osc_32k;
  always @(posedge mclk)
  begin
    cyc++;
    ticks += sec_tick;
    irqs += irq_n_oe & ~irq_q;
    irq_q <= irq_n_oe;
    if (cyc == 60000)
    begin
      failures++;
      results;
    end
  end

  rtcp_host_model host_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  rtcp_timer #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) rtcp_timer_i (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .time_halt(time_halt), .ext_clock_test_enable(ext_clock_test_enable),
    .countdown_irq_pulse_mode(countdown_irq_pulse_mode), .countdown_flag_clear(countdown_flag_clear),
    .osc_32k(osc_32k), .clock_output_pin_in(pin), .clock_output_pin_out(pin_out),
    .clock_output_pin_oe(pin_oe), .countdown_flag(countdown_flag), .sec_tick(sec_tick),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_flag(output int t);
    for (int n = 0; n < 5000 && countdown_flag !== 1'b1; n++)
      @(posedge mclk);
    #1 t = cyc;
  endtask
  task automatic clear_flag;
    countdown_flag_clear = 1;
    wt(1);
    countdown_flag_clear = 0;
  endtask
  task automatic pulses(int n);
    repeat (n)
    begin
      ext_drv = 1;
      wt(4);
      ext_drv = 0;
      wt(4);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    host_i.rd(8'h0D, d); chk("clk out ctrl", d, 8'h80);
    host_i.rd(8'h0E, d); chk("cd ctrl", d, 8'h03);
    host_i.rd(8'h10, d); chk("unmapped", d, 8'h00);
    chk("pin oe", pin_oe, 1'b1);
    host_i.wr(8'h0D, 8'h7D);
    wt(4); chk("pin oe", pin_oe, 1'b0);
    host_i.rd(8'h0D, d); chk("clk out ctrl", d, 8'h01);
  endtask
  task automatic t_clk_out;
    int e[8] = '{512, 16, 1, 0, 512, 0, 0, 0};
    int r;
    logic p;
    for (int i = 0; i < 8; i++)
    begin
      time_halt = i[2];
      host_i.wr(8'h0D, {6'h20, i[1:0]});
      wt(300);
      r = 0;
      p = pin;
      repeat (4096)
      begin
        wt(1);
        r += pin & ~p;
        p = pin;
      end
      #1 chk("clk out rises", r >= e[i] - 1 && r <= e[i] + 1, 1'b1);
    end
    time_halt = 0;
  endtask
  task automatic t_countdown;
    int t0, t1;
    host_i.wr(8'h0F, 8'h03);
    host_i.wr(8'h0E, 8'h80);
    wait_flag(t0);
    clear_flag;
    wait_flag(t1);
    chk("period", t1 - t0, 16'd192);
    wt(1);
    chk("level irq", irq_n_oe, 1'b1);
    wt(95);
    host_i.rd_twice(8'h0F, d); chk("live count", d, 8'h02);
    clear_flag;
    wt(3); chk("irq off", irq_n_oe, 1'b0);
  endtask
  task automatic t_pulse;
    int t, i0, t1;
    countdown_irq_pulse_mode = 1;
    host_i.wr(8'h0F, 8'h01);
    wait_flag(t);
    i0 = irqs;
    wt(192);
    chk("irq pulses", irqs - i0, 16'd3);
    chk("flag held", countdown_flag, 1'b1);
    host_i.wr(8'h0E, 8'h00);
    host_i.wr(8'h0F, 8'h05);
    clear_flag;
    wt(300);
    host_i.rd(8'h0F, d); chk("disabled count", d, 8'h05);
    // 64 Hz source: one tick per 512 oscillator edges
    host_i.wr(8'h0F, 8'h01);
    host_i.wr(8'h0E, 8'h81);
    wait_flag(t);
    clear_flag;
    wait_flag(t1);
    chk("64hz period", t1 - t, 16'd4096);
    clear_flag;
    host_i.wr(8'h0E, 8'h00);
  endtask
  task automatic t_ext;
    int t0;
    ext_clock_test_enable = 1;
    time_halt = 1; // prescaler state unknown until halt set and cleared
    wt(4); chk("pin oe", pin_oe, 1'b0);
    t0 = ticks;
    pulses(64); chk("halted ticks", ticks - t0, 16'd0);
    time_halt = 0;
    pulses(31); chk("ticks", ticks - t0, 16'd0);
    pulses(1); chk("ticks", ticks - t0, 16'd1);
    pulses(63); chk("ticks", ticks - t0, 16'd1);
    pulses(1); chk("ticks", ticks - t0, 16'd2);
    ext_clock_test_enable = 0;
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    wt(20);
    reset_n = 1;
    t_reset;
    t_clk_out;
    t_countdown;
    t_pulse;
    t_ext;
    host_i.wr(8'h0E, 8'h03); // idle timer parked on slowest source
    results;
  end
endmodule // rtcp_timer_test

bind rtcp_timer rtcp_timer_monitor #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) mon_i (.mclk(mclk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .time_halt(time_halt),
  .ext_clock_test_enable(ext_clock_test_enable), .countdown_irq_pulse_mode(countdown_irq_pulse_mode),
  .countdown_flag_clear(countdown_flag_clear), .osc_32k(osc_32k),
  .clock_output_pin_in(clock_output_pin_in), .clock_output_pin_out(clock_output_pin_out),
  .clock_output_pin_oe(clock_output_pin_oe), .countdown_flag(countdown_flag),
  .sec_tick(sec_tick), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
